//--- pipelined_sync_sram_port_tb_top.sv
`timescale 1ns/10ps
module pipelined_sync_sram_port_tb_top;
  import pssp_pkg::*;
  logic ref_clk;
  logic rstn;
  pssp_req_type req_data;
  logic req_valid;
  logic req_ready;
  logic [DATA_W-1:0] wdata;
  logic stall;
  logic [DATA_W-1:0] rdata;
  logic rdata_valid;
  logic sleep_active;
  logic [DATA_W-1:0] mem [4];
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  pssp_if bus ();
  pssp_host pssp_host_inst (.ref_clk(ref_clk), .rstn(rstn), .req_data(req_data), .req_valid(req_valid),
    .req_ready(req_ready), .wdata(wdata), .stall(stall), .rdata(rdata), .rdata_valid(rdata_valid), .bus(bus));
  pssp_device pssp_device_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .sleep_active(sleep_active),
    .last_addr());
  pssp_chk pssp_chk_inst (.ref_clk(ref_clk), .rstn(rstn), .read_write(bus.read_write),
    .advance_or_load(bus.advance_or_load), .chip_select_a_n(bus.chip_select_a_n),
    .chip_select_b(bus.chip_select_b), .chip_select_c_n(bus.chip_select_c_n), .clock_gate_n(bus.clock_gate_n),
    .burst_order_select_oe(bus.burst_order_select_oe), .sleep_request_oe(bus.sleep_request_oe),
    .output_drive_enable_n(bus.output_drive_enable_n), .dq_dev_oe(bus.dq_dev_oe), .dq_host_oe(bus.dq_host_oe));
  // ********************************
  // tasks
  // ********************************
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // valid stays up between back-to-back requests so it never toggles twice in one step
  task automatic push(input logic [ADDR_W-1:0] a, input logic wr, input logic bu, input logic [LANES-1:0] ln,
      input logic [DATA_W-1:0] d, input logic last);
    req_data = '{addr: a, write: wr, burst: bu, lanes_n: ln};
    wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    #1;
    if (last) req_valid = 1'b0;
  endtask
  // count write beats on the wire; wdata is held until all are taken
  task automatic drain(input int beats);
    int k;
    k = 0;
    for (int i = 0; i < 60 && k < beats; i++) begin
      @(negedge ref_clk);
      if (bus.dq_host_oe === 1'b1 && bus.clock_gate_n === 1'b0) k++;
    end
    cmp(DATA_W'(k), DATA_W'(beats));
    @(posedge ref_clk);
    #1;
  endtask
  task automatic take(input logic [DATA_W-1:0] exp);
    int i;
    i = 0;
    while (rdata_valid !== 1'b1 && i < 60) begin
      @(negedge ref_clk);
      i++;
    end
    cmp(rdata, exp);
    @(posedge ref_clk);
    #1;
  endtask
  task automatic stall_for();
    @(posedge ref_clk);
    #1 stall = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 stall = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ********************************
  // clock, ceiling and tests
  // ********************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // a hang runs into the ceiling well past the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_data = '0;
    wdata = '0;
    stall = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      mem[i] = 36'h1_2345_6789 + 36'h1_1111_1111 * DATA_W'(i);
      push(10'h010 + 10'(i), 1'b1, 1'b0, 4'h0, mem[i], 1'b1);
      drain(1);
    end
    push(10'h012, 1'b0, 1'b0, 4'h0, '0, 1'b0);
    push(10'h013, 1'b0, 1'b0, 4'h0, '0, 1'b1);
    take(mem[2]);
    take(mem[3]);
    $display("single and back-to-back done");
    push(10'h011, 1'b0, 1'b1, 4'h0, '0, 1'b1);
    for (int k = 0; k < BURST_LEN; k++) take(mem[1 ^ k]);
    $display("interleaved burst done");
    push(10'h012, 1'b1, 1'b0, 4'he, 36'hf_ffff_ffff, 1'b1);
    drain(1);
    mem[2][8:0] = 9'h1ff;
    push(10'h013, 1'b1, 1'b0, LANES_NONE, 36'h0_0000_0000, 1'b1);
    drain(1);
    push(10'h010, 1'b0, 1'b1, 4'h0, '0, 1'b1);
    fork
      stall_for();
      for (int k = 0; k < BURST_LEN; k++) take(mem[k]);
    join
    $display("lanes and gated read done");
    push(10'h020, 1'b1, 1'b1, 4'h0, 36'ha_5a5a_5a5a, 1'b1);
    fork
      stall_for();
      drain(BURST_LEN);
    join
    push(10'h022, 1'b0, 1'b1, 4'h0, '0, 1'b1);
    for (int k = 0; k < BURST_LEN; k++) take(36'ha_5a5a_5a5a);
    cmp({35'h0, sleep_active}, 36'h0);
    $display("gated burst write done");
    report_and_stop();
  end
endmodule

//--- pssp_chk.sv
`timescale 1ns/10ps
module pssp_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic read_write,
  input wire logic advance_or_load,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic clock_gate_n,
  input wire logic burst_order_select_oe,
  input wire logic sleep_request_oe,
  input wire logic output_drive_enable_n,
  input wire logic dq_dev_oe,
  input wire logic dq_host_oe
);
  import pssp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic sel;
  logic ld;
  logic [1:0] adv_q;
  logic [1:0] adv_d;
  // ********************************
  // helpers
  // ********************************
  assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign ld = !clock_gate_n && !advance_or_load && sel;
  // advances since the last enabled non-advance edge, load or deselect; gated edges count nothing
  always_comb begin
    adv_d = adv_q;
    if (!clock_gate_n) begin
      adv_d = advance_or_load ? adv_q + 2'h1 : 2'h0;
    end
  end
  always_ff @(posedge ref_clk) begin
    adv_q <= rstn ? adv_d : 2'h0;
  end
  // ********************************
  // assertions
  // ********************************
  a_no_bus_fight: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive the data bus");
  a_reset_quiet: assert property ($rose(rstn) |-> clock_gate_n && !dq_dev_oe && !dq_host_oe)
    else $error("bus not idle after reset");
  a_read_due: assert property (ld && read_write ##1 !clock_gate_n ##1 !output_drive_enable_n |-> dq_dev_oe)
    else $error("read data not driven two enabled cycles after load");
  a_write_due: assert property (ld && !read_write ##1 !clock_gate_n |=> dq_host_oe)
    else $error("write data not presented two enabled cycles after load");
  a_gated_hold: assert property (clock_gate_n |=> $stable(dq_dev_oe))
    else $error("gated edge changed the output drive");
  a_deselect_quiet: assert property ((!clock_gate_n && !advance_or_load && !sel) [*3] |-> !dq_dev_oe)
    else $error("device drove the bus with nothing pending");
  a_burst_four: assert property (!clock_gate_n && advance_or_load |-> adv_q != 2'h3)
    else $error("burst longer than four beats");
  a_straps_free: assert property (!burst_order_select_oe && !sleep_request_oe)
    else $error("strap pin driven by host");
  c_long_burst: cover property (adv_q == 2'h3);
  c_gated_read: cover property (clock_gate_n && dq_dev_oe);
  c_host_write: cover property (dq_host_oe && !clock_gate_n);
endmodule

//--- pssp_device.sv
`timescale 1ns/10ps
module pssp_device #(
  parameter int WORDS = 1 << pssp_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  pssp_if.device bus,
  output logic sleep_active,
  output logic [pssp_pkg::ADDR_W-1:0] last_addr
);
  import pssp_pkg::*;
  initial begin
    if (WORDS != (1 << ADDR_W)) $error("word count must match address width");
  end
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [1:0] beat;
    logic write;
    logic [PIPE_DEPTH-1:0] vld;
    logic [PIPE_DEPTH-1:0] wr;
    logic [ADDR_W-1:0] a1;
    logic [ADDR_W-1:0] a2;
    logic [LANES-1:0] ln1;
    logic [LANES-1:0] ln2;
    logic [DATA_W-1:0] dout;
    logic drive;
    logic sleep;
    logic [ADDR_W-1:0] last;
  } pssp_dev_type;
  pssp_dev_type s_q;
  pssp_dev_type s_d;
  logic [DATA_W-1:0] mem [WORDS];
  logic selected;
  logic order_il;
  logic sleep_in;
  logic [ADDR_W-1:0] cur_addr;
  logic issue;
  logic mem_we;
  // burst address for a given beat
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] b, input logic [1:0] k,
                                                   input logic il);
    logic [1:0] lo;
    lo = il ? (b[1:0] ^ k) : (b[1:0] + k);
    return {b[ADDR_W-1:2], lo};
  endfunction
  // strap defaults for undriven pins
  assign order_il = bus.burst_order_select_oe ? bus.burst_order_select_n : 1'b1;
  assign sleep_in = bus.sleep_request_oe ? bus.sleep_request : 1'b0;
  assign selected = !bus.chip_select_a_n && !bus.chip_select_c_n && bus.chip_select_b;
  // ********************************
  // pipeline
  // ********************************
  always_comb begin
    s_d = s_q;
    issue = 1'b0;
    cur_addr = '0;
    mem_we = 1'b0;
    s_d.sleep = sleep_in;
    if (!bus.clock_gate_n) begin
      if (bus.advance_or_load) begin
        // continue burst, address and chip selects ignored; byte lanes still sampled
        issue = s_q.vld[0] || s_q.beat != BEAT_ZERO;
        s_d.beat = s_q.beat + BEAT_ONE;
        cur_addr = burst_addr(s_q.base, s_d.beat, order_il);
      end else if (selected) begin
        issue = 1'b1;
        s_d.base = bus.addr;
        s_d.beat = BEAT_ZERO;
        s_d.write = !bus.read_write;
        cur_addr = bus.addr;
      end else begin
        s_d.beat = BEAT_ZERO;
      end
      // a burst only advances after an actual load
      if (bus.advance_or_load && !s_q.write && !s_q.vld[0] && s_q.beat == BEAT_ZERO) begin
        issue = 1'b0;
      end
      s_d.vld = {s_q.vld[0], issue};
      s_d.wr = {s_q.wr[0], issue && s_d.write};
      s_d.a1 = cur_addr;
      s_d.a2 = s_q.a1;
      s_d.ln1 = bus.byte_lane_write_n;
      s_d.ln2 = s_q.ln1;
      if (issue) begin
        s_d.last = cur_addr;
      end
      // data phase two enabled clocks after load
      mem_we = s_q.vld[1] && s_q.wr[1];
      // read word registered one enabled edge after load so it stands in cycle n+2
      // limitation: a read loaded right after a write to the same word sees the old word
      s_d.drive = s_q.vld[0] && !s_q.wr[0] && !bus.output_drive_enable_n;
      if (s_q.vld[0] && !s_q.wr[0]) begin
        s_d.dout = mem[s_q.a1];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // lane-wise write
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (mem_we && !s_q.ln2[i]) begin
        mem[s_q.a2][i*LANE_W +: LANE_W] <= bus.dq[i*LANE_W +: LANE_W];
      end
    end
  end
  assign bus.dq_dev_o = s_q.dout;
  assign bus.dq_dev_oe = s_q.drive;
  assign sleep_active = s_q.sleep;
  assign last_addr = s_q.last;
endmodule

//--- pssp_fifo.sv
`timescale 1ns/10ps
module pssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic [PW:0] fill;
  // honest full and empty from pointer distance
  assign fill = wr_q - rd_q;
  assign in_ready = fill != (PW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = mem[rd_q[PW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
  // storage carries no reset
  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end
endmodule

//--- pssp_host.sv
`timescale 1ns/10ps
module pssp_host (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire pssp_pkg::pssp_req_type req_data,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [pssp_pkg::DATA_W-1:0] wdata,
  input wire logic stall,
  output logic [pssp_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid,
  pssp_if.host bus
);
  import pssp_pkg::*;
  // ********************************
  // request queue
  // ********************************
  pssp_req_type q_data;
  logic q_valid;
  logic q_take;
  pssp_fifo #(.WIDTH(CMD_W - 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(req_data),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_take)
  );
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rw;
    logic adv;
    logic sel;
    logic gate_n;
    logic [LANES-1:0] lanes_n;
    logic [1:0] beats;
    logic [PIPE_DEPTH-1:0] wv;
    logic [PIPE_DEPTH-1:0] rv;
    logic [DATA_W-1:0] w1;
    logic [DATA_W-1:0] dout;
    logic drive;
    logic [PIPE_DEPTH-1:0] cap;
    logic [DATA_W-1:0] rd;
    logic rdv;
  } pssp_host_type;
  pssp_host_type s_q;
  pssp_host_type s_d;
  logic issue;
  // ********************************
  // command and data pipeline
  // ********************************
  always_comb begin
    s_d = s_q;
    q_take = 1'b0;
    s_d.gate_n = stall;
    s_d.rdv = 1'b0;
    issue = 1'b0;
    // an enabled edge is one where the gate we drove was low
    if (!s_q.gate_n) begin
      s_d.wv = {s_q.wv[0], 1'b0};
      s_d.rv = {s_q.rv[0], 1'b0};
      s_d.drive = s_q.wv[1];
      s_d.dout = s_q.w1;
      s_d.cap = {s_q.cap[0], s_q.rv[1]};
      if (s_q.sel && s_q.rv[1] == 1'b0 && s_q.cap[0]) begin
        s_d.rd = bus.dq;
      end
      if (s_q.cap[0]) begin
        s_d.rd = bus.dq;
        s_d.rdv = 1'b1;
      end
      if (s_q.beats != BEAT_ZERO) begin
        // keep advancing with lane enables valid
        s_d.adv = 1'b1;
        s_d.sel = 1'b0;
        s_d.beats = s_q.beats - BEAT_ONE;
        issue = 1'b1;
      end else if (q_valid && !stall) begin
        q_take = 1'b1;
        s_d.adv = 1'b0;
        s_d.sel = 1'b1;
        s_d.addr = q_data.addr;
        s_d.rw = !q_data.write;
        s_d.lanes_n = q_data.write ? q_data.lanes_n : LANES_NONE;
        s_d.beats = q_data.burst ? 2'(BURST_LEN - 1) : BEAT_ZERO;
        issue = 1'b1;
      end else begin
        s_d.adv = 1'b0;
        s_d.sel = 1'b0;
      end
      if (issue) begin
        s_d.wv[0] = !s_d.rw;
        s_d.rv[0] = s_d.rw;
        s_d.w1 = wdata;
      end
    end
    if (stall && s_q.beats != BEAT_ZERO) begin
      s_d.gate_n = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.gate_n <= 1'b1;
      s_q.rw <= 1'b1;
      s_q.lanes_n <= LANES_NONE;
    end else begin
      s_q <= s_d;
    end
  end
  // ********************************
  // pins
  // ********************************
  assign bus.addr = s_q.addr;
  assign bus.read_write = s_q.rw;
  assign bus.advance_or_load = s_q.adv;
  assign bus.byte_lane_write_n = s_q.lanes_n;
  assign bus.chip_select_a_n = !s_q.sel;
  assign bus.chip_select_b = s_q.sel;
  assign bus.chip_select_c_n = !s_q.sel;
  assign bus.clock_gate_n = s_q.gate_n;
  assign bus.burst_order_select_n = 1'b1;
  assign bus.burst_order_select_oe = 1'b0;
  assign bus.sleep_request = 1'b0;
  assign bus.sleep_request_oe = 1'b0;
  assign bus.output_drive_enable_n = 1'b0;
  assign bus.dq_host_o = s_q.dout;
  assign bus.dq_host_oe = s_q.drive;
  assign rdata = s_q.rd;
  assign rdata_valid = s_q.rdv;
endmodule

//--- pssp_if.sv
`timescale 1ns/10ps
interface pssp_if;
  import pssp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic read_write;
  logic advance_or_load;
  logic [LANES-1:0] byte_lane_write_n;
  logic chip_select_a_n;
  logic chip_select_b;
  logic chip_select_c_n;
  logic clock_gate_n;
  logic burst_order_select_n;
  logic burst_order_select_oe;
  logic sleep_request;
  logic sleep_request_oe;
  logic output_drive_enable_n;
  logic [DATA_W-1:0] dq_host_o;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_dev_o;
  logic dq_dev_oe;
  wire [DATA_W-1:0] dq = dq_dev_oe ? dq_dev_o : dq_host_o;
  modport device (
    input addr, read_write, advance_or_load, byte_lane_write_n, chip_select_a_n, chip_select_b,
    input chip_select_c_n, clock_gate_n, burst_order_select_n, burst_order_select_oe,
    input sleep_request, sleep_request_oe, output_drive_enable_n, dq,
    output dq_dev_o, dq_dev_oe
  );
  modport host (
    output addr, read_write, advance_or_load, byte_lane_write_n, chip_select_a_n, chip_select_b,
    output chip_select_c_n, clock_gate_n, burst_order_select_n, burst_order_select_oe,
    output sleep_request, sleep_request_oe, output_drive_enable_n, dq_host_o, dq_host_oe,
    input dq
  );
endinterface

//--- pssp_pkg.sv
package pssp_pkg;
  // ********************************
  // geometry
  // ********************************
  localparam int ADDR_W = 10;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = 36;
  localparam int BURST_LEN = 4;
  localparam int PIPE_DEPTH = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int CMD_W = ADDR_W + 1 + 1 + LANES + 1;
  // ********************************
  // constants
  // ********************************
  localparam logic [1:0] BEAT_ONE = 2'h1;
  localparam logic [1:0] BEAT_ZERO = 2'h0;
  localparam logic [LANES-1:0] LANES_NONE = 4'hf;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic burst;
    logic [LANES-1:0] lanes_n;
  } pssp_req_type;
endpackage
